/* File: core/sbc_pkg.sv */
// Shared constants of the synthesizer and bit-rate control block.
package sbc_pkg;
  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_CTRL = 8'h01; // Control bits.
  localparam logic [7:0] IDX_STAT = 8'h02; // Status bits.
  localparam logic [7:0] IDX_CF_MSB = 8'h07; // Carrier word bits 23:16.
  localparam logic [7:0] IDX_CF_MID = 8'h08; // Carrier word bits 15:8.
  localparam logic [7:0] IDX_CF_LSB = 8'h09; // Carrier word bits 7:0.
  localparam logic [7:0] IDX_BR_MSB = 8'h0a; // Divisor bits 15:8.
  localparam logic [7:0] IDX_BR_LSB = 8'h0b; // Divisor bits 7:0.
  // Control register field positions.
  localparam int C_SEQ = 0; // Built-in sequencer enable.
  localparam int C_TX = 1; // One selects transmit, zero receive.
  localparam int C_RUN = 2; // Start request.
  localparam int C_CONT = 3; // Continuous mode.
  localparam int C_GAUSS = 4; // Gaussian shaping enable.
  localparam int C_CLK_LO = 5; // Low bit of reference output select.
  localparam int C_CLK_HI = 7; // High bit of reference output select.
  localparam int C_EXTREF = 8; // External reference select.
  localparam int C_SLEEP = 9; // Sleep mode.
  localparam int C_LOCKMAP = 10; // Lock indicator mapped to its pin.
  localparam int C_MANPLL = 11; // Manual synthesizer enable.
  localparam int CTRL_W = 12; // Width of the control register.
  // Reset values.
  localparam logic [11:0] CTRL_RST = 12'h000; // Reference output on.
  localparam logic [23:0] CF_RST = 24'h00_0000; // Carrier word default.
  localparam logic [15:0] BR_RST = 16'h682b; // Divisor default.
  localparam logic [2:0] CLK_OFF = 3'h7; // Select code that stops output.
  // Synthesizer split of the carrier word.
  localparam int FRAC_W = 19; // Fractional modulator width.
  localparam int CF_W = 24; // Carrier word width.
  // Sequencer states.
  typedef enum logic [1:0] {
    SBC_IDLE,
    SBC_OSC,
    SBC_PLL,
    SBC_RUN
  } sbc_state_t;
endpackage

/* File: core/sbc_buf2.sv */
`timescale 1ns/1ps
// Two-entry buffer with valid and ready on both sides.
module sbc_buf2 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2]; // Storage for the two entries.
  logic wr_q; // Write pointer.
  logic rd_q; // Read pointer.
  logic [1:0] cnt_q; // Number of entries held.
  logic push; // Entry accepted this cycle.
  logic pop; // Entry delivered this cycle.

  // Full and empty come straight from the count.
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written without reset; the count guards reads.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers move on every accepted push or pop; the count holds when both come in one cycle.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  buf_count_bound_a: assert property (cnt_q <= 2'h2)
    else $error("Buffer count exceeds two entries.");
  buf_full_cv: cover property (cnt_q == 2'h2);
endmodule // sbc_buf2

/* File: core/sbc_ctrl.sv */
`timescale 1ns/1ps
module sbc_ctrl #(
  parameter int AW = 12
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_stable_i,
  input wire logic pll_lock_i,
  input wire logic serial_data_pin,
  input wire logic mod_ready,
  output logic mod_bit,
  output logic mod_valid,
  output logic data_clock_pin,
  output logic general_pin_five,
  output logic lock_pin,
  output logic [4:0] synth_int,
  output logic [18:0] synth_frac,
  output logic carrier_update,
  output logic pll_en,
  output logic fine_cal,
  output logic coarse_cal,
  output logic rx_en,
  output logic tx_en,
  output logic external_reference_select
);
  initial begin
    if (AW < 10) begin
      $error("Address width too small for the register map.");
    end
  end

  // Register state.
  logic [sbc_pkg::CTRL_W-1:0] ctrl_q; // Control register.
  logic [7:0] cf_msb_q; // Pending carrier bits 23:16.
  logic [7:0] cf_mid_q; // Pending carrier bits 15:8.
  logic [sbc_pkg::CF_W-1:0] carrier_word_q; // Applied carrier word.
  logic [15:0] bit_rate_divisor_q; // Bit-rate divisor.
  logic [31:0] prdata_q; // Read data.
  logic pready_q; // Access-phase ready.
  logic pslverr_q; // Unmapped access flag.
  logic upd_q; // Carrier applied pulse.
  // Sequencer and timing state.
  sbc_pkg::sbc_state_t state_q; // Sequencer state.
  logic pll_en_q; // Synthesizer enable.
  logic fine_q; // Fine calibration pulse.
  logic coarse_q; // Coarse calibration pulse.
  logic coarse_done_q; // Coarse calibration already run.
  logic rx_q; // Receiver enable.
  logic tx_q; // Transmitter enable.
  logic lock_q; // Lock indicator.
  logic lock_pin_q; // Lock indicator on its pin.
  logic [15:0] bit_cnt_q; // Bit period counter.
  logic bitclk_q; // Data clock pulse.
  logic mod_bit_q; // Bit handed to the modulator.
  logic mod_vld_q; // Modulator bit valid.
  logic [7:0] div_q; // Free-running divider for the reference output.
  logic refout_q; // Reference output pin.
  // Combinational helpers.
  logic acc; // Access phase this cycle.
  logic wr; // Write takes effect this cycle.
  logic [7:0] idx; // Register index from the address.
  logic hit; // Address is word aligned within the map.
  logic go; // Sequencer start request.
  logic pll_en_d; // Next synthesizer enable.
  logic shaped; // Gaussian continuous transmit active.
  logic tick; // A new bit is due.
  logic [15:0] term; // Last count of a bit period.
  logic [2:0] clk_sel; // Reference output select.
  logic buf_in_ready; // Buffer can take a bit.
  logic buf_out_valid; // Buffer holds a bit.
  logic buf_out_bit; // Oldest buffered bit.
  logic buf_pop; // Modulator takes a bit this cycle.

  assign acc = psel && penable;
  assign wr = acc && pwrite && pready_q;
  assign idx = paddr[9:2];
  assign hit = (paddr[1:0] == 2'b00) && (paddr[AW-1:10] == '0);
  assign go = ctrl_q[sbc_pkg::C_SEQ] && ctrl_q[sbc_pkg::C_RUN] &&
              !ctrl_q[sbc_pkg::C_SLEEP];
  assign clk_sel = ctrl_q[sbc_pkg::C_CLK_HI:sbc_pkg::C_CLK_LO];

  // Ready is raised in the setup cycle so every access takes one wait-free
  // access phase; read data and error are latched at the same time.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= 1'b0;
      if (psel && !penable) begin
        prdata_q <= 32'h0000_0000;
        if (!hit) begin
          pslverr_q <= 1'b1;
        end else if (idx == sbc_pkg::IDX_CTRL) begin
          prdata_q <= {20'h0_0000, ctrl_q};
        end else if (idx == sbc_pkg::IDX_STAT) begin
          prdata_q <= {27'h000_0000, state_q, coarse_done_q, lock_q,
                       osc_stable_i};
        end else if (idx == sbc_pkg::IDX_CF_MSB) begin
          prdata_q <= {24'h00_0000, cf_msb_q};
        end else if (idx == sbc_pkg::IDX_CF_MID) begin
          prdata_q <= {24'h00_0000, cf_mid_q};
        end else if (idx == sbc_pkg::IDX_CF_LSB) begin
          prdata_q <= {24'h00_0000, carrier_word_q[7:0]};
        end else if (idx == sbc_pkg::IDX_BR_MSB) begin
          prdata_q <= {24'h00_0000, bit_rate_divisor_q[15:8]};
        end else if (idx == sbc_pkg::IDX_BR_LSB) begin
          prdata_q <= {24'h00_0000, bit_rate_divisor_q[7:0]};
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  // Register writes; upper carrier bytes only wait for the low byte.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q <= sbc_pkg::CTRL_RST;
      cf_msb_q <= sbc_pkg::CF_RST[23:16];
      cf_mid_q <= sbc_pkg::CF_RST[15:8];
      carrier_word_q <= sbc_pkg::CF_RST;
      bit_rate_divisor_q <= sbc_pkg::BR_RST;
      upd_q <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      if (wr && hit) begin
        if (idx == sbc_pkg::IDX_CTRL) begin
          ctrl_q <= pwdata[sbc_pkg::CTRL_W-1:0];
        end else if (idx == sbc_pkg::IDX_CF_MSB) begin
          cf_msb_q <= pwdata[7:0];
        end else if (idx == sbc_pkg::IDX_CF_MID) begin
          cf_mid_q <= pwdata[7:0];
        end else if (idx == sbc_pkg::IDX_CF_LSB) begin
          carrier_word_q <= {cf_msb_q, cf_mid_q, pwdata[7:0]};
          upd_q <= 1'b1;
        end else if (idx == sbc_pkg::IDX_BR_MSB) begin
          bit_rate_divisor_q[15:8] <= pwdata[7:0];
        end else if (idx == sbc_pkg::IDX_BR_LSB) begin
          bit_rate_divisor_q[7:0] <= pwdata[7:0];
        end
      end
    end
  end

  // Sequencer: oscillator, then synthesizer, then receive or transmit.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= sbc_pkg::SBC_IDLE;
    end else if (!go) begin
      state_q <= sbc_pkg::SBC_IDLE;
    end else begin
      case (state_q)
        sbc_pkg::SBC_IDLE: begin
          state_q <= sbc_pkg::SBC_OSC;
        end
        sbc_pkg::SBC_OSC: begin
          if (osc_stable_i) begin
            state_q <= sbc_pkg::SBC_PLL;
          end
        end
        sbc_pkg::SBC_PLL: begin
          if (pll_lock_i) begin
            state_q <= sbc_pkg::SBC_RUN;
          end
        end
        default: begin
          state_q <= sbc_pkg::SBC_RUN;
        end
      endcase
    end
  end

  // The synthesizer runs in the sequencer's late states, or on the manual
  // bit when software sequences startup itself.
  always_comb begin
    if (ctrl_q[sbc_pkg::C_SEQ]) begin
      pll_en_d = go && ((state_q == sbc_pkg::SBC_PLL) ||
                        (state_q == sbc_pkg::SBC_RUN) ||
                        ((state_q == sbc_pkg::SBC_OSC) && osc_stable_i));
    end else begin
      pll_en_d = ctrl_q[sbc_pkg::C_MANPLL] && !ctrl_q[sbc_pkg::C_SLEEP];
    end
  end

  // Enables, calibration pulses and the lock indicator.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pll_en_q <= 1'b0;
      fine_q <= 1'b0;
      coarse_q <= 1'b0;
      coarse_done_q <= 1'b0;
      rx_q <= 1'b0;
      tx_q <= 1'b0;
      lock_q <= 1'b0;
      lock_pin_q <= 1'b0;
    end else begin
      pll_en_q <= pll_en_d;
      fine_q <= pll_en_d && !pll_en_q;
      coarse_q <= osc_stable_i && !coarse_done_q;
      if (osc_stable_i) begin
        coarse_done_q <= 1'b1;
      end
      if (ctrl_q[sbc_pkg::C_SEQ]) begin
        rx_q <= go && (state_q == sbc_pkg::SBC_RUN) &&
                !ctrl_q[sbc_pkg::C_TX];
        tx_q <= go && (state_q == sbc_pkg::SBC_RUN) &&
                ctrl_q[sbc_pkg::C_TX];
      end else begin
        // Software alone decides when lock has been reached.
        rx_q <= ctrl_q[sbc_pkg::C_RUN] && !ctrl_q[sbc_pkg::C_TX];
        tx_q <= ctrl_q[sbc_pkg::C_RUN] && ctrl_q[sbc_pkg::C_TX];
      end
      lock_q <= pll_en_q && pll_lock_i;
      lock_pin_q <= ctrl_q[sbc_pkg::C_LOCKMAP] && pll_en_q &&
                    pll_lock_i;
    end
  end

  // Bit timer: one period is the divisor in reference cycles; it holds at
  // its last count while the buffer is full, so no bit is lost.
  assign shaped = ctrl_q[sbc_pkg::C_CONT] && ctrl_q[sbc_pkg::C_GAUSS] &&
                  tx_q;
  assign term = bit_rate_divisor_q - 16'h0001;
  assign tick = shaped && (bit_cnt_q >= term) && buf_in_ready;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bit_cnt_q <= 16'h0000;
      bitclk_q <= 1'b0;
    end else begin
      bitclk_q <= tick;
      if (!shaped || tick) begin
        bit_cnt_q <= 16'h0000;
      end else if (bit_cnt_q < term) begin
        bit_cnt_q <= bit_cnt_q + 16'h0001;
      end
    end
  end

  // Shaped bits pass the buffer; plain continuous bits go straight on.
  assign buf_pop = buf_out_valid && mod_ready && shaped;
  sbc_buf2 #(
    .W(1)
  ) u_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(tick),
    .in_ready(buf_in_ready),
    .in_data(serial_data_pin),
    .out_valid(buf_out_valid),
    .out_ready(mod_ready && shaped),
    .out_data(buf_out_bit)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mod_bit_q <= 1'b0;
      mod_vld_q <= 1'b0;
    end else if (ctrl_q[sbc_pkg::C_CONT] && !ctrl_q[sbc_pkg::C_GAUSS]) begin
      mod_bit_q <= serial_data_pin;
      mod_vld_q <= 1'b1;
    end else begin
      mod_vld_q <= buf_pop;
      if (buf_pop) begin
        mod_bit_q <= buf_out_bit;
      end
    end
  end

  // Reference output: divided by two to the select plus one, stopped
  // before the oscillator is stable, asleep, or on the off code.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      div_q <= 8'h00;
      refout_q <= 1'b0;
    end else begin
      div_q <= div_q + 8'h01;
      refout_q <= osc_stable_i && !ctrl_q[sbc_pkg::C_SLEEP] &&
                  (clk_sel != sbc_pkg::CLK_OFF) &&
                  div_q[clk_sel];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mod_bit = mod_bit_q;
  assign mod_valid = mod_vld_q;
  assign data_clock_pin = bitclk_q;
  assign general_pin_five = refout_q;
  assign lock_pin = lock_pin_q;
  assign synth_int = carrier_word_q[23:sbc_pkg::FRAC_W];
  assign synth_frac = carrier_word_q[sbc_pkg::FRAC_W-1:0];
  assign carrier_update = upd_q;
  assign pll_en = pll_en_q;
  assign fine_cal = fine_q;
  assign coarse_cal = coarse_q;
  assign rx_en = rx_q;
  assign tx_en = tx_q;
  assign external_reference_select = ctrl_q[sbc_pkg::C_EXTREF];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  carrier_apply_a: assert property (
    (wr && hit && idx == sbc_pkg::IDX_CF_LSB) |=> carrier_update)
    else $error("Low byte write did not apply the carrier.");
  upper_hold_a: assert property (
    (wr && idx != sbc_pkg::IDX_CF_LSB) |=> $stable(carrier_word_q))
    else $error("Carrier changed without a low byte write.");
  frac_map_a: assert property (
    (wr && hit && idx == sbc_pkg::IDX_CF_LSB) |=>
      synth_frac[7:0] == $past(pwdata[7:0]))
    else $error("Low carrier byte not at bits 7:0.");
  int_map_a: assert property (
    (wr && hit && idx == sbc_pkg::IDX_CF_LSB) |=>
      synth_int == $past(cf_msb_q[7:3]))
    else $error("Integer part not above nineteen fraction bits.");
  bit_period_a: assert property (
    $rose(bitclk_q) |-> $past(bit_cnt_q) >= $past(term))
    else $error("Data clock before the divisor elapsed.");
  bitclk_pulse_a: assert property (bitclk_q |=> !bitclk_q)
    else $error("Data clock pulse wider than one cycle.");
  async_pass_a: assert property (
    (ctrl_q[sbc_pkg::C_CONT] && !ctrl_q[sbc_pkg::C_GAUSS]) |=>
      mod_bit == $past(serial_data_pin))
    else $error("Plain continuous data not passed through.");
  pll_auto_a: assert property (
    (go && state_q == sbc_pkg::SBC_OSC && osc_stable_i) |=> pll_en)
    else $error("Synthesizer not started on stable oscillator.");
  run_after_lock_a: assert property (
    (go && state_q == sbc_pkg::SBC_PLL && pll_lock_i) ##1 go |=>
      (rx_en || tx_en))
    else $error("No receive or transmit start after lock.");
  refout_gate_a: assert property (!osc_stable_i |=> !general_pin_five)
    else $error("Reference output before oscillator stable.");
  fine_cal_a: assert property ($rose(pll_en) |-> fine_cal)
    else $error("No fine calibration on synthesizer start.");
  lock_low_a: assert property (!pll_en |=> !lock_q)
    else $error("Lock indicated with synthesizer off.");
  carrier_cv: cover property (carrier_update);
  bitclk_cv: cover property (bitclk_q ##1 !bitclk_q);
  run_cv: cover property (state_q == sbc_pkg::SBC_RUN && tx_en);
  stall_cv: cover property (shaped && !buf_in_ready);
endmodule // sbc_ctrl

/* File: verif/sbc_host_model.sv */
`timescale 1ns/1ps
// Host side of the data pins: feeds a fixed bit pattern, one bit per
// data clock pulse, or a level that the bench sets directly.
module sbc_host_model #(
  parameter logic [15:0] PAT = 16'hb38e
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic data_clock_pin,
  input wire logic async_en,
  input wire logic async_bit,
  output logic serial_data_pin
);
  logic [3:0] idx_q; // Index of the bit now presented.
  // Step to the next bit after each pulse, long before the next sample.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idx_q <= 4'h0;
    end else if (data_clock_pin) begin
      idx_q <= idx_q + 4'h1;
    end
  end
  // Without shaping the level bears no relation to any clock.
  assign serial_data_pin = async_en ? async_bit : PAT[idx_q];
endmodule // sbc_host_model

/* File: verif/test_synth_and_bit_rate_divisor_value_control.sv */
`timescale 1ns/1ps
// Self-checking bench of the synthesizer and bit-rate control block.
module test_synth_and_bit_rate_divisor_value_control;
  localparam logic [15:0] PAT = 16'hb38e; // Bits the host sends.
  localparam int LIMIT = 6000; // Cycle ceiling for the whole run.
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, osc_stable_i = 1'b0;
  logic pll_lock_i = 1'b0, mod_ready = 1'b1, async_en = 1'b0;
  logic async_bit = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [4:0] synth_int;
  logic [18:0] synth_frac;
  logic pready, pslverr, serial_data_pin, mod_bit, mod_valid, lock_pin;
  logic data_clock_pin, general_pin_five, carrier_update, pll_en;
  logic fine_cal, coarse_cal, rx_en, tx_en, external_reference_select;
  int err_total = 0, compares = 0, cyc = 0, pulse_n = 0, pulse_last = 0;
  int pulse_gap = 0, rises = 0, cu_n = 0, fine_n = 0, coarse_n = 0;
  logic collect = 1'b0; // Shaped bits are gathered only while set.
  logic gp5_prev = 1'b0; // Last level of the reference output.
  logic got_q[$]; // Bits handed to the modulator, in order.

  // The clock toggles every half period of 2 ns.
  always #2 clk_sys = ~clk_sys;

  sbc_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_stable_i(osc_stable_i), .pll_lock_i(pll_lock_i),
    .serial_data_pin(serial_data_pin), .mod_ready(mod_ready),
    .mod_bit(mod_bit), .mod_valid(mod_valid),
    .data_clock_pin(data_clock_pin), .general_pin_five(general_pin_five),
    .lock_pin(lock_pin), .synth_int(synth_int), .synth_frac(synth_frac),
    .carrier_update(carrier_update), .pll_en(pll_en), .fine_cal(fine_cal),
    .coarse_cal(coarse_cal), .rx_en(rx_en), .tx_en(tx_en),
    .external_reference_select(external_reference_select));

  sbc_host_model #(.PAT(PAT)) host (.clk_sys(clk_sys), .rstn(rstn),
    .data_clock_pin(data_clock_pin), .async_en(async_en),
    .async_bit(async_bit), .serial_data_pin(serial_data_pin));

  // Counts pulses and edges seen at each rising edge; cuts off a hang.
  always @(posedge clk_sys) begin
    cyc++;
    if (data_clock_pin === 1'b1) begin
      pulse_n++;
      pulse_gap = cyc - pulse_last;
      pulse_last = cyc;
    end
    if (collect && mod_valid === 1'b1) got_q.push_back(mod_bit);
    if (general_pin_five === 1'b1 && gp5_prev === 1'b0) rises++;
    gp5_prev = general_pin_five;
    cu_n += int'(carrier_update === 1'b1);
    fine_n += int'(fine_cal === 1'b1);
    coarse_n += int'(coarse_cal === 1'b1);
    if (cyc == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got,
               exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high, and
  // only the bench's cycle ceiling ends a wait that never answers.
  task automatic apb(input logic we, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register read with a comparison, and a plain register write.
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input string what);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 32'h0000_0000, d, e);
    chk(d, exp, what);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
  endtask

  // Defaults after reset, the slow rate divisor among them.
  task automatic t_reset();
    rd(sbc_pkg::IDX_CTRL, 32'h0000_0000, "ctrl");
    rd(sbc_pkg::IDX_CF_LSB, 32'h0000_0000, "carrier");
    rd(sbc_pkg::IDX_BR_MSB, 32'h0000_0068, "divisor high");
    rd(sbc_pkg::IDX_BR_LSB, 32'h0000_002b, "divisor low");
    chk(32'({pll_en, lock_pin, tx_en, rx_en}), 0, "idle");
    $display("reset test done");
  endtask

  // Upper bytes wait; the low byte applies all three at once.
  task automatic t_carrier();
    logic [31:0] d;
    logic e;
    wr(sbc_pkg::IDX_CF_MSB, 32'h0000_00ab);
    wr(sbc_pkg::IDX_CF_MID, 32'h0000_00cd);
    repeat (2) @(posedge clk_sys);
    chk(32'(cu_n), 0, "early update");
    chk(32'({synth_int, synth_frac}), 0, "carrier held");
    wr(sbc_pkg::IDX_CF_LSB, 32'h0000_00ef);
    repeat (2) @(posedge clk_sys);
    chk(32'(cu_n), 1, "update pulse");
    chk(32'({synth_int, synth_frac}), 32'h00ab_cdef, "carrier");
    rd(sbc_pkg::IDX_CF_MSB, 32'h0000_00ab, "carrier high");
    apb(1'b0, 8'h0c, 32'h0000_0000, d, e);
    chk(32'(e), 1, "unmapped error");
    chk(d, 0, "unmapped data");
    $display("carrier test done");
  endtask

  // Counts reference output rises over 64 cycles for one setting.
  task automatic refcnt(input logic [31:0] ctl, input int exp);
    int r0;
    int tol;
    tol = (exp == 0) ? 0 : 1;
    wr(sbc_pkg::IDX_CTRL, ctl);
    repeat (4) @(posedge clk_sys);
    r0 = rises;
    repeat (64) @(posedge clk_sys);
    r0 = rises - r0;
    chk(32'(r0 >= exp - tol && r0 <= exp + tol), 1, "reference rate");
  endtask
  task automatic t_refout();
    refcnt(32'h0000_0000, 0);
    osc_stable_i <= 1'b1;
    refcnt(32'h0000_0000, 32);
    refcnt(32'h0000_0020, 16);
    refcnt(32'h0000_0040, 8);
    refcnt(32'h0000_00e0, 0);
    refcnt(32'h0000_0200, 0);
    wr(sbc_pkg::IDX_CTRL, 32'h0000_0100);
    repeat (2) @(posedge clk_sys);
    chk(32'(external_reference_select), 1, "external ref");
    chk(32'(coarse_n), 1, "coarse calibration");
    $display("reference test done");
  endtask

  // Built-in sequencer: synthesizer, then transmitter after lock.
  task automatic t_seq();
    int n;
    wr(sbc_pkg::IDX_CTRL, 32'h0000_0407);
    for (n = 0; n < 20 && pll_en !== 1'b1; n++) @(posedge clk_sys);
    chk(32'(pll_en), 1, "synth start");
    repeat (2) @(posedge clk_sys);
    chk(32'(fine_n), 1, "fine calibration");
    repeat (10) @(posedge clk_sys);
    chk(32'(tx_en), 0, "start before lock");
    pll_lock_i <= 1'b1;
    for (n = 0; n < 20 && tx_en !== 1'b1; n++) @(posedge clk_sys);
    chk(32'({tx_en, rx_en}), 2, "transmitter start");
    repeat (3) @(posedge clk_sys);
    chk(32'(lock_pin), 1, "lock indicator");
    $display("sequencer test done");
  endtask

  // Shaped stream: bit period, stall while the buffer is full, order.
  task automatic t_shaped();
    int n;
    int p0;
    wr(sbc_pkg::IDX_BR_MSB, 32'h0000_0000);
    wr(sbc_pkg::IDX_BR_LSB, 32'h0000_0005);
    collect = 1'b1;
    wr(sbc_pkg::IDX_CTRL, 32'h0000_041f);
    for (n = 0; n < 200 && got_q.size() < 6; n++) @(posedge clk_sys);
    chk(32'(pulse_gap), 5, "bit period");
    mod_ready <= 1'b0;
    repeat (16) @(posedge clk_sys);
    p0 = pulse_n;
    repeat (40) @(posedge clk_sys);
    chk(32'(pulse_n - p0), 0, "pulse while full");
    mod_ready <= 1'b1;
    for (n = 0; n < 400 && got_q.size() < 16; n++) @(posedge clk_sys);
    chk(32'(got_q.size() >= 16), 1, "bit count");
    for (n = 0; n < 16; n++) begin
      chk(32'(got_q[n]), 32'(PAT[n]), "bit order");
    end
    collect = 1'b0;
    $display("shaped test done");
  endtask

  // Plain continuous mode passes the pin straight through.
  task automatic t_plain();
    int n;
    async_en <= 1'b1;
    wr(sbc_pkg::IDX_CTRL, 32'h0000_040f);
    for (n = 0; n < 4; n++) begin
      async_bit <= n[0] ^ n[1];
      repeat (3) @(posedge clk_sys);
      chk(32'(mod_bit), 32'(n[0] ^ n[1]), "direct data");
    end
    chk(32'(mod_valid), 1, "direct valid");
    $display("plain test done");
  endtask

  // Software sequencing: check lock in status, then start the receiver.
  task automatic t_manual();
    wr(sbc_pkg::IDX_CTRL, 32'h0000_0800);
    rd(sbc_pkg::IDX_STAT, 32'h0000_0007, "status");
    wr(sbc_pkg::IDX_CTRL, 32'h0000_0804);
    repeat (2) @(posedge clk_sys);
    chk(32'({pll_en, tx_en, rx_en}), 32'h0000_0005, "manual rx");
    chk(32'(lock_pin), 0, "lock unmapped");
    $display("manual test done");
  endtask

  // Reset for 12 cycles, then run every test in turn.
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_carrier();
    t_refout();
    t_seq();
    t_shaped();
    t_plain();
    t_manual();
    wrap_up();
  end
endmodule // test_synth_and_bit_rate_divisor_value_control
